// *** mrt_phy_model.sv ***
// mrt_phy_model: gmii link partner, sends whole frames on a gated clock
// assumes an 80 ns link clock whose phase offset is set by PH
`timescale 1ns/100ps

module mrt_phy_model #(
   parameter int PH = 13
)(
   output logic lclk,
   output logic [7:0] d,
   output logic dv
);
   logic run = 1'b1;
   initial begin
      lclk = 1'b0;
      d = 8'hAA;
      dv = 1'b0;
      #PH;
      forever #40 lclk = run ? ~lclk : 1'b0;
   end
   // preamble, start delimiter, then the header bytes first byte first
   task automatic send(input logic [191:0] f);
      logic [255:0] s;
      s = {56'h55555555555555, 8'hD5, f};
      run = 1'b1;
      repeat (2) @(negedge lclk);
      dv = 1'b1;
      repeat (32) begin
         d = s[255:248];
         s = s << 8;
         @(negedge lclk);
      end
      dv = 1'b0;
      // released data lines toggle between the last byte's inverse and the last byte, ending on the last byte
      repeat (6) begin
         d = ~d;
         @(negedge lclk);
      end
      run = 1'b0;
   endtask
endmodule

// *** mrt_pkg.sv ***
// mrt_pkg: constants shared by the receive filter, timer and ptp logic
// assumes gmii byte streams and a timer clocked by the main clock
// Function
// - four address filters match source or destination, bytes maskable
// - frames that pass filtering go to dma, others are dropped
// - four type-id matchers, each enabled on its own
// - number of address filters is a build value from 0 to 4
// - timer is 48-bit seconds, 30-bit nanoseconds, 16-bit sub-ns
// - timer advances every clock, pulse on each seconds increment
// - software can read, load and adjust the timer
// - adjust mode: 11 normal, 01 one ns more, 10 one ns less
// - code 00 with step select high: clear ns, seconds+1 each clock
// - code 00 with step select low: normal, copy to sync strobe reg
// - compare 48 seconds and upper 22 ns bits, flag on equality
// - increment mode ignores the fabric timer controls
// - start-of-frame sampled into timer domain after synchronising
// - timestamp used for one-step insert, capture regs and dma
// - sync recognised by 802.1AS and 1588 addresses together
// - rx and tx strobes for delay req, pdelay req, pdelay resp, sync
// - start-of-frame strobes rise at sfd and hold to frame end
// - tx strobes on tx clock, rx strobes on rx clock
// - credit shaping on two top queues, selectable queuing method
// - eight queue gates cycle periodically from a programmed time
// - stream identification and duplicate elimination, no replication
package mrt_pkg;
   localparam int NUM_FILT = 4;
   localparam int NUM_TYPE = 4;
   localparam int NUM_Q = 8;
   localparam logic [7:0] SFD = 8'hD5;
   localparam logic [15:0] ETH_PTP = 16'h88F7;
   localparam logic [15:0] ETH_RTAG = 16'hF1C1;
   localparam logic [47:0] AS_MCAST = 48'h0180C200000E;
   localparam logic [47:0] PTP_MCAST = 48'h011B19000000;
   localparam logic [4:0] IDX_SA = 5'h06;
   localparam logic [4:0] IDX_TYPE = 5'h0C;
   localparam logic [4:0] IDX_MSG = 5'h0E;
   localparam logic [4:0] IDX_SEQ = 5'h10;
   localparam logic [4:0] IDX_END = 5'h11;
   localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
   localparam logic [1:0] INC_NORMAL = 2'h3;
   localparam logic [1:0] INC_PLUS = 2'h1;
   localparam logic [1:0] INC_MINUS = 2'h2;
   localparam logic [1:0] INC_HOLD = 2'h0;
   localparam logic [1:0] QSEL_FIXED = 2'h0;
   localparam logic [1:0] QSEL_ETS = 2'h2;
   typedef enum logic [1:0] {PS_IDLE, PS_HDR, PS_BODY} mrt_pstate_t;
endpackage

// *** mrt_top.sv ***
// mrt_top: receive filter, ptp strobes, timestamp timer and tsn queue
// control; assumes config ports are held steady while frames flow
`timescale 1ns/100ps

module mrt_frame_parse
   import mrt_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] d,
   input wire logic dv,
   output logic sof,
   output logic [47:0] da,
   output logic [47:0] sa,
   output logic [15:0] etype,
   output logic [15:0] seq,
   output logic hdr_done,
   output logic eof,
   output logic sof_tgl,
   output logic [3:0] ptp_msg
);
   mrt_pstate_t st_ff;
   logic [4:0] idx_ff;
   logic is_ptp;
   logic at_sfd;

   assign at_sfd = st_ff == PS_IDLE && dv && d == SFD;
   assign is_ptp = etype == ETH_PTP && (da == AS_MCAST || da == PTP_MCAST);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= PS_IDLE;
      end else begin
         unique case (st_ff)
            PS_IDLE: if (at_sfd) st_ff <= PS_HDR;
            PS_HDR: begin
               if (!dv) st_ff <= PS_IDLE;
               else if (idx_ff == IDX_END) st_ff <= PS_BODY;
            end
            PS_BODY: if (!dv) st_ff <= PS_IDLE;
            default: st_ff <= PS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_ff <= 5'h00;
         da <= 48'h0;
         sa <= 48'h0;
         etype <= 16'h0;
         seq <= 16'h0;
      end else if (at_sfd) begin
         idx_ff <= 5'h00;
      end else if (st_ff == PS_HDR && dv) begin
         idx_ff <= idx_ff + 5'h01;
         if (idx_ff < IDX_SA) da <= {da[39:0], d};
         else if (idx_ff < IDX_TYPE) sa <= {sa[39:0], d};
         else if (idx_ff < IDX_MSG) etype <= {etype[7:0], d};
         else if (idx_ff >= IDX_SEQ) seq <= {seq[7:0], d};
      end
   end

   // frame-long sof and ptp strobes, ended by the frame's own dv; hdr_done and eof pulse for one clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sof <= 1'b0;
         ptp_msg <= 4'h0;
         sof_tgl <= 1'b0;
         hdr_done <= 1'b0;
         eof <= 1'b0;
      end else begin
         hdr_done <= st_ff == PS_HDR && dv && idx_ff == IDX_END;
         eof <= st_ff != PS_IDLE && !dv;
         if (at_sfd) begin
            sof <= 1'b1;
            sof_tgl <= ~sof_tgl;
         end else if (!dv) begin
            sof <= 1'b0;
            ptp_msg <= 4'h0;
         end
         if (st_ff == PS_HDR && dv && idx_ff == IDX_MSG && is_ptp &&
             d[3:2] == 2'h0)
            ptp_msg <= 4'h1 << d[1:0];
      end
   end

   a_sof_follows: assert property (@(posedge clk) disable iff (!rst_n)
      at_sfd |=> sof ##1 (sof || !$past(dv)))
      else $error("sof did not rise and hold after sfd");
endmodule

module mrt_top
   import mrt_pkg::*;
#(
   parameter int NUM_ADDR_FILT = 4
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_clk,
   input wire logic [7:0] rxd,
   input wire logic rx_dv,
   input wire logic tx_clk,
   input wire logic [7:0] txd,
   input wire logic tx_en,
   input wire logic [NUM_FILT*48-1:0] filt_addr,
   input wire logic [NUM_FILT*6-1:0] filt_byte_mask,
   input wire logic [NUM_FILT-1:0] filt_use_sa,
   input wire logic [NUM_FILT-1:0] filt_en,
   input wire logic [NUM_TYPE*16-1:0] type_id,
   input wire logic [NUM_TYPE-1:0] type_en,
   input wire logic promisc,
   input wire logic elim_en,
   output logic frame_pass,
   output logic frame_drop,
   input wire logic tsu_adjust_mode,
   input wire logic [1:0] tsu_inc_ctrl,
   input wire logic seconds_step_select,
   input wire logic [7:0] incr_ns,
   input wire logic [15:0] incr_sub,
   input wire logic tmr_wr,
   input wire logic [47:0] tmr_wr_sec,
   input wire logic [29:0] tmr_wr_ns,
   input wire logic [15:0] tmr_wr_sub,
   input wire logic tmr_adj,
   input wire logic tmr_adj_neg,
   input wire logic [29:0] tmr_adj_ns,
   output logic [47:0] tmr_sec,
   output logic [29:0] tmr_ns,
   output logic [15:0] tmr_sub,
   output logic sec_pulse,
   output logic [47:0] sync_sec,
   output logic [29:0] sync_ns,
   input wire logic [47:0] cmp_sec,
   input wire logic [21:0] cmp_ns_hi,
   output logic timer_cmp_match,
   input wire logic one_step_en,
   output logic [47:0] rx_ts_sec,
   output logic [29:0] rx_ts_ns,
   output logic [47:0] tx_ts_sec,
   output logic [29:0] tx_ts_ns,
   output logic dma_rx_ts_valid,
   output logic dma_tx_ts_valid,
   output logic tx_ins_req,
   output logic sof_rx,
   output logic sync_rx,
   output logic dreq_rx,
   output logic pdreq_rx,
   output logic pdresp_rx,
   output logic sof_tx,
   output logic sync_tx,
   output logic dreq_tx,
   output logic pdreq_tx,
   output logic pdresp_tx,
   input wire logic [NUM_Q-1:0] q_pending,
   input wire logic [NUM_Q-1:0] q_sending,
   input wire logic cbs_en,
   input wire logic [1:0] qsel,
   input wire logic [15:0] idle_slope,
   input wire logic [15:0] send_slope,
   input wire logic gate_en,
   input wire logic [47:0] gate_start_sec,
   input wire logic [29:0] gate_start_ns,
   input wire logic [15:0] gate_cycle,
   input wire logic [NUM_Q*16-1:0] gate_on,
   output logic [NUM_Q-1:0] q_gate_open,
   output logic [2:0] q_grant,
   output logic q_grant_valid
);
   function automatic logic mrt_addr_eq(input logic [47:0] a,
                                        input logic [47:0] b,
                                        input logic [5:0] msk);
      logic eq;
      eq = 1'b1;
      for (int i = 0; i < 6; i++)
         if (!msk[i] && a[8*i+:8] != b[8*i+:8]) eq = 1'b0;
      return eq;
   endfunction

   logic [47:0] rx_da, rx_sa;
   logic [15:0] rx_type, rx_seq;
   logic rx_hdr, rx_eof, rx_tgl, tx_tgl;
   logic [3:0] rx_msg, tx_msg;

   // rx and tx strobes stay in their own link clock domains
   mrt_frame_parse u_rx_parse (
      .clk(rx_clk), .rst_n(rst_n), .d(rxd), .dv(rx_dv), .sof(sof_rx),
      .da(rx_da), .sa(rx_sa), .etype(rx_type), .seq(rx_seq),
      .hdr_done(rx_hdr), .eof(rx_eof), .sof_tgl(rx_tgl), .ptp_msg(rx_msg));
   mrt_frame_parse u_tx_parse (
      .clk(tx_clk), .rst_n(rst_n), .d(txd), .dv(tx_en), .sof(sof_tx),
      .da(), .sa(), .etype(), .seq(), .hdr_done(), .eof(),
      .sof_tgl(tx_tgl), .ptp_msg(tx_msg));

   assign sync_rx = rx_msg[0];
   assign dreq_rx = rx_msg[1];
   assign pdreq_rx = rx_msg[2];
   assign pdresp_rx = rx_msg[3];
   assign sync_tx = tx_msg[0];
   assign dreq_tx = tx_msg[1];
   assign pdreq_tx = tx_msg[2];
   assign pdresp_tx = tx_msg[3];

   // receive filter, rx_clk domain
   logic [NUM_FILT-1:0] amatch;
   logic [NUM_TYPE-1:0] tmatch;
   logic [1:0] fidx;
   logic dup;
   logic [15:0] last_seq_ff [NUM_FILT];
   logic [NUM_FILT-1:0] seen_ff;
   logic pass_ff, res_ff, dec_tgl_ff;

   always_comb begin
      amatch = '0;
      tmatch = '0;
      fidx = 2'h0;
      for (int f = 0; f < NUM_ADDR_FILT; f++)
         amatch[f] = filt_en[f] && mrt_addr_eq(filt_use_sa[f] ? rx_sa : rx_da,
            filt_addr[f*48+:48], filt_byte_mask[f*6+:6]);
      for (int t = 0; t < NUM_TYPE; t++)
         tmatch[t] = type_en[t] && rx_type == type_id[t*16+:16];
      for (int f = NUM_FILT - 1; f >= 0; f--)
         if (amatch[f]) fidx = 2'(f);
      dup = elim_en && rx_type == ETH_RTAG && |amatch && seen_ff[fidx] &&
            last_seq_ff[fidx] == rx_seq;
   end

   // stream table: one sequence slot per address filter
   always_ff @(posedge rx_clk or negedge rst_n) begin
      if (!rst_n) begin
         seen_ff <= '0;
         for (int f = 0; f < NUM_FILT; f++) last_seq_ff[f] <= 16'h0;
      end else if (rx_hdr && elim_en && rx_type == ETH_RTAG && |amatch) begin
         seen_ff[fidx] <= 1'b1;
         last_seq_ff[fidx] <= rx_seq;
      end
   end

   always_ff @(posedge rx_clk or negedge rst_n) begin
      if (!rst_n) begin
         pass_ff <= 1'b0;
         res_ff <= 1'b0;
         dec_tgl_ff <= 1'b0;
      end else begin
         if (rx_hdr) pass_ff <= (|amatch || |tmatch || promisc) && !dup;
         if (rx_eof) begin
            res_ff <= pass_ff;
            pass_ff <= 1'b0;
            dec_tgl_ff <= ~dec_tgl_ff;
         end
      end
   end

   // crossings into clk: toggles for events, level for tx sync
   logic [2:0] ev_s1_ff, ev_s2_ff, ev_s3_ff;
   logic [2:0] ev;
   assign ev = ev_s2_ff ^ ev_s3_ff;

   logic dec_s1_ff, dec_s2_ff, dec_s3_ff;
   function automatic logic dec_s3_xor();
      return dec_s2_ff ^ dec_s3_ff;
   endfunction

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev_s1_ff <= 3'h0;
         ev_s2_ff <= 3'h0;
         ev_s3_ff <= 3'h0;
         frame_pass <= 1'b0;
         frame_drop <= 1'b0;
         tx_ins_req <= 1'b0;
      end else begin
         ev_s1_ff <= {sync_tx, tx_tgl, rx_tgl};
         ev_s2_ff <= ev_s1_ff;
         ev_s3_ff <= ev_s2_ff;
         frame_pass <= dec_s3_xor() && res_ff;
         frame_drop <= dec_s3_xor() && !res_ff;
         tx_ins_req <= one_step_en && ev[2] && ev_s2_ff[2];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dec_s1_ff <= 1'b0;
         dec_s2_ff <= 1'b0;
         dec_s3_ff <= 1'b0;
      end else begin
         dec_s1_ff <= dec_tgl_ff;
         dec_s2_ff <= dec_s1_ff;
         dec_s3_ff <= dec_s2_ff;
      end
   end

   // timestamp timer, clk domain
   logic [47:0] sec_ff;
   logic [29:0] ns_ff;
   logic [15:0] sub_ff;
   logic [1:0] ctrl;
   logic step;
   logic [16:0] sub_sum;
   logic [31:0] ns_sum;
   logic [47:0] nxt_sec;
   logic [29:0] nxt_ns;
   logic sec_up;

   assign ctrl = tsu_adjust_mode ? tsu_inc_ctrl : INC_NORMAL;
   assign step = ctrl == INC_HOLD && tsu_adjust_mode && seconds_step_select;
   assign tmr_sec = sec_ff;
   assign tmr_ns = ns_ff;
   assign tmr_sub = sub_ff;

   always_comb begin
      sub_sum = {1'b0, sub_ff} + {1'b0, incr_sub};
      ns_sum = {2'h0, ns_ff} + {24'h0, incr_ns} + {31'h0, sub_sum[16]};
      if (ctrl == INC_PLUS) ns_sum = ns_sum + 32'h1;
      if (ctrl == INC_MINUS) ns_sum = ns_sum - 32'h1;
      if (tmr_adj && tmr_adj_neg) ns_sum = ns_sum - {2'h0, tmr_adj_ns};
      else if (tmr_adj) ns_sum = ns_sum + {2'h0, tmr_adj_ns};
      nxt_sec = sec_ff;
      nxt_ns = ns_sum[29:0];
      sec_up = 1'b0;
      if (ns_sum[31]) begin
         nxt_ns = 30'(ns_sum + NS_PER_SEC);
         nxt_sec = sec_ff - 48'h1;
      end else if (ns_sum >= NS_PER_SEC) begin
         nxt_ns = 30'(ns_sum - NS_PER_SEC);
         nxt_sec = sec_ff + 48'h1;
         sec_up = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sec_ff <= 48'h0;
         ns_ff <= 30'h0;
         sub_ff <= 16'h0;
         sec_pulse <= 1'b0;
      end else begin
         sec_pulse <= !tmr_wr && (step || sec_up);
         if (tmr_wr) begin
            sec_ff <= tmr_wr_sec;
            ns_ff <= tmr_wr_ns;
            sub_ff <= tmr_wr_sub;
         end else if (step) begin
            ns_ff <= 30'h0;
            sec_ff <= sec_ff + 48'h1;
         end else begin
            sec_ff <= nxt_sec;
            ns_ff <= nxt_ns;
            sub_ff <= sub_sum[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_sec <= 48'h0;
         sync_ns <= 30'h0;
         timer_cmp_match <= 1'b0;
      end else begin
         if (tsu_adjust_mode && ctrl == INC_HOLD && !seconds_step_select) begin
            sync_sec <= sec_ff;
            sync_ns <= ns_ff;
         end
         timer_cmp_match <= {sec_ff, ns_ff[29:8]} == {cmp_sec, cmp_ns_hi};
      end
   end

   // timestamps sampled on synchronised start-of-frame events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_ts_sec <= 48'h0;
         rx_ts_ns <= 30'h0;
         tx_ts_sec <= 48'h0;
         tx_ts_ns <= 30'h0;
         dma_rx_ts_valid <= 1'b0;
         dma_tx_ts_valid <= 1'b0;
      end else begin
         dma_rx_ts_valid <= ev[0];
         dma_tx_ts_valid <= ev[1];
         if (ev[0]) begin
            rx_ts_sec <= sec_ff;
            rx_ts_ns <= ns_ff;
         end
         if (ev[1]) begin
            tx_ts_sec <= sec_ff;
            tx_ts_ns <= ns_ff;
         end
      end
   end

   // queue gates: one cycle counter, per-queue open window
   logic started_ff;
   logic [15:0] gcnt_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         started_ff <= 1'b0;
         gcnt_ff <= 16'h0;
         q_gate_open <= '1;
      end else begin
         if (!gate_en) started_ff <= 1'b0;
         else if ({sec_ff, ns_ff} >= {gate_start_sec, gate_start_ns})
            started_ff <= 1'b1;
         if (!started_ff || gcnt_ff >= gate_cycle - 16'h1) gcnt_ff <= 16'h0;
         else gcnt_ff <= gcnt_ff + 16'h1;
         for (int q = 0; q < NUM_Q; q++)
            q_gate_open[q] <= !started_ff || gcnt_ff < gate_on[q*16+:16];
      end
   end

   // credit shaping on the two highest queues
   logic signed [23:0] credit_ff [2];
   logic [NUM_Q-1:0] cbs_ok, elig;
   logic [2:0] rr_ff, gq, qi;
   logic gv;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < 2; k++) credit_ff[k] <= 24'sh0;
      end else begin
         for (int k = 0; k < 2; k++) begin
            if (!cbs_en) credit_ff[k] <= 24'sh0;
            else if (q_sending[NUM_Q-1-k])
               credit_ff[k] <= credit_ff[k] - $signed({8'h0, send_slope});
            else if (q_pending[NUM_Q-1-k])
               credit_ff[k] <= credit_ff[k] + $signed({8'h0, idle_slope});
            else if (credit_ff[k] > 24'sh0) credit_ff[k] <= 24'sh0;
         end
      end
   end

   always_comb begin
      cbs_ok = '1;
      for (int k = 0; k < 2; k++)
         cbs_ok[NUM_Q-1-k] = !cbs_en || !credit_ff[k][23];
      elig = q_pending & q_gate_open & cbs_ok;
      gv = 1'b0;
      gq = 3'h0;
      qi = 3'h0;
      if (qsel == QSEL_FIXED) begin
         for (int q = 0; q < NUM_Q; q++)
            if (elig[q]) begin
               gv = 1'b1;
               gq = 3'(q);
            end
      end else begin
         for (int i = 1; i <= NUM_Q; i++) begin
            qi = rr_ff + 3'(i);
            if (!gv && elig[qi]) begin
               gv = 1'b1;
               gq = qi;
            end
         end
         if (qsel == QSEL_ETS)
            for (int q = NUM_Q - 2; q < NUM_Q; q++)
               if (elig[q]) begin
                  gv = 1'b1;
                  gq = 3'(q);
               end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rr_ff <= 3'h0;
         q_grant <= 3'h0;
         q_grant_valid <= 1'b0;
      end else begin
         q_grant_valid <= gv;
         q_grant <= gq;
         if (gv) rr_ff <= gq;
      end
   end

   a_ns_in_range: assert property (@(posedge clk) disable iff (!rst_n)
      ns_ff < NS_PER_SEC)
      else $error("nanoseconds reached one billion");
   a_sec_step: assert property (@(posedge clk) disable iff (!rst_n)
      step && !tmr_wr |=> ns_ff == 30'h0 && sec_ff == $past(sec_ff) + 48'h1)
      else $error("seconds step did not clear ns and bump seconds");
   a_sync_copy: assert property (@(posedge clk) disable iff (!rst_n)
      tsu_adjust_mode && tsu_inc_ctrl == INC_HOLD && !seconds_step_select
      |=> sync_sec == $past(sec_ff) && sync_ns == $past(ns_ff))
      else $error("sync strobe register missed timer copy");
   a_cmp_flag: assert property (@(posedge clk) disable iff (!rst_n)
      {sec_ff, ns_ff[29:8]} == {cmp_sec, cmp_ns_hi} |=> timer_cmp_match)
      else $error("compare match not raised");
   a_inc_gated: assert property (@(posedge clk) disable iff (!rst_n)
      !tsu_adjust_mode && !tmr_wr && !tmr_adj && ns_ff < 30'h3B000000
      |=> ns_ff == $past(ns_ff) + $past(incr_ns) + $past(sub_sum[16]))
      else $error("increment mode timer step wrong");
   a_plus_one: assert property (@(posedge clk) disable iff (!rst_n)
      tsu_adjust_mode && tsu_inc_ctrl == INC_PLUS && !tmr_wr && !tmr_adj &&
      ns_ff < 30'h3B000000
      |=> ns_ff == $past(ns_ff) + $past(incr_ns) + $past(sub_sum[16]) + 1)
      else $error("adjust plus code did not add one ns");
   a_sec_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      sec_pulse |-> sec_ff == $past(sec_ff) + 48'h1)
      else $error("seconds pulse without seconds increment");
   a_ts_sample: assert property (@(posedge clk) disable iff (!rst_n)
      ev[0] |=> rx_ts_sec == $past(sec_ff) && dma_rx_ts_valid)
      else $error("rx timestamp not sampled on sof event");
   a_pass_xor_drop: assert property (@(posedge clk) disable iff (!rst_n)
      !(frame_pass && frame_drop))
      else $error("frame both passed and dropped");
endmodule

// *** mrt_top_test.sv ***
// mrt_top_test: self-checking bench for filter, timer, strobes and queues
// assumes mrt_phy_model drives both gmii links with gated clocks
`timescale 1ns/100ps

module mrt_top_test;
   import mrt_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, promisc = 1'b0, elim_en = 1'b1;
   logic tmr_wr = 1'b0, tsu_adjust_mode = 1'b0, seconds_step_select = 1'b0;
   logic tmr_adj = 1'b0, tmr_adj_neg = 1'b0, one_step_en = 1'b0;
   logic cbs_en = 1'b0, gate_en = 1'b0;
   logic [7:0] incr_ns = 8'h08, q_pending = 8'h00, q_sending = 8'h00;
   logic [15:0] incr_sub = 16'h0000, tmr_wr_sub = 16'h0000;
   logic [15:0] idle_slope = 16'h0010, send_slope = 16'h0010;
   logic [15:0] gate_cycle = 16'h000A;
   logic [47:0] tmr_wr_sec = '0, cmp_sec = '0, gate_start_sec = '0, da;
   logic [29:0] tmr_wr_ns = '0, tmr_adj_ns = 30'h32, gate_start_ns = '0;
   logic [NUM_FILT*48-1:0] filt_addr = '0;
   logic [23:0] filt_byte_mask = '0;
   logic [3:0] filt_use_sa = 4'h0, filt_en = 4'h0, type_en = 4'h0;
   logic [63:0] type_id = '0;
   logic [1:0] tsu_inc_ctrl = INC_NORMAL, qsel = QSEL_FIXED;
   logic [21:0] cmp_ns_hi = '0;
   logic [127:0] gate_on = '0;
   logic rx_clk, rx_dv, tx_clk, tx_en, frame_pass, frame_drop, sec_pulse;
   logic timer_cmp_match, dma_rx_ts_valid, dma_tx_ts_valid, tx_ins_req;
   logic sof_rx, sync_rx, dreq_rx, pdreq_rx, pdresp_rx, q_grant_valid;
   logic sof_tx, sync_tx, dreq_tx, pdreq_tx, pdresp_tx;
   logic [7:0] rxd, txd, q_gate_open;
   logic [47:0] tmr_sec, sync_sec, rx_ts_sec, tx_ts_sec;
   logic [29:0] tmr_ns, sync_ns, rx_ts_ns, tx_ts_ns;
   logic [15:0] tmr_sub;
   logic [2:0] q_grant;
   logic [31:0] sd = 32'h00000040;
   logic [4:0] seen;
   logic [2:0] sofs = 3'h0;
   logic [1:0] c;
   logic [29:0] n;
   int miscompares = 0, cmp_count = 0, npass, ndrop, nts, nins, nsec, nsof;
   int cnt [8];

   mrt_top u_mrt_top (.*);
   mrt_phy_model #(.PH(13)) u_prx (.lclk(rx_clk), .d(rxd), .dv(rx_dv));
   mrt_phy_model #(.PH(29)) u_ptx (.lclk(tx_clk), .d(txd), .dv(tx_en));

   always #4 clk = ~clk;
   always @(posedge clk) begin
      npass += (frame_pass === 1'b1);
      ndrop += (frame_drop === 1'b1);
      nts += (dma_rx_ts_valid === 1'b1) + (dma_tx_ts_valid === 1'b1);
      nins += (tx_ins_req === 1'b1);
      nsec += (sec_pulse === 1'b1);
      sofs <= {sofs[1:0], sof_rx | sof_tx};
      nsof += (sofs[1] === 1'b1 && sofs[2] === 1'b0);
   end
   always @(posedge rx_clk) seen <= seen | {sof_rx, sync_rx, dreq_rx,
      pdreq_rx, pdresp_rx};
   always @(posedge tx_clk) seen <= seen | {sof_tx, sync_tx, dreq_tx,
      pdreq_tx, pdresp_tx};

   function automatic logic [31:0] rnd();
      sd ^= sd << 13;
      sd ^= sd >> 17;
      sd ^= sd << 5;
      return sd;
   endfunction
   function automatic logic [4:0] xs(input logic [47:0] a,
      input logic [15:0] t, input logic [3:0] m);
      logic p;
      p = t == ETH_PTP && (a == AS_MCAST || a == PTP_MCAST);
      return {1'b1, p && m == 0, p && m == 1, p && m == 2, p && m == 3};
   endfunction
   function automatic logic [2:0] hi(input logic [7:0] v);
      hi = 3'h0;
      for (int i = 0; i < 8; i++) if (v[i]) hi = i[2:0];
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tstep(input logic [1:0] k, input logic m, input logic am,
      input logic aj, input logic [47:0] s, input logic [29:0] v,
      input logic [47:0] es, input logic [29:0] ev);
      @(negedge clk);
      tmr_wr = 1'b1;
      tmr_wr_sec = s;
      tmr_wr_ns = v;
      @(negedge clk);
      tmr_wr = 1'b0;
      tsu_inc_ctrl = k;
      seconds_step_select = m;
      tsu_adjust_mode = am;
      tmr_adj = aj;
      @(negedge clk);
      tmr_adj = 1'b0;
      tsu_inc_ctrl = INC_NORMAL;
      seconds_step_select = 1'b0;
      check({tmr_sec, tmr_ns[29:0] == ev}, {es, 1'b1});
   endtask
   task automatic frame(input logic tx, input logic [47:0] a,
      input logic [15:0] t, input logic [3:0] m, input int ep);
      logic [191:0] f;
      logic [4:0] ex;
      f = {a, 48'h020000000001, t, 4'h0, m, 8'h02, 16'h0001, 48'h0};
      ex = xs(a, t, m);
      seen = '0;
      nsof = 0;
      npass = 0;
      ndrop = 0;
      nts = 0;
      nins = 0;
      if (tx) u_ptx.send(f);
      else u_prx.send(f);
      repeat (12) @(negedge clk);
      check(seen, ex);
      check(nsof, 1);
      check({sof_rx, sof_tx}, 0);
      check({npass, ndrop}, {ep, tx ? 0 : 1 - ep});
      check(nts, 1);
      check(nins, tx && one_step_en && ex[3]);
   endtask
   task automatic test_done();
      $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
      if (miscompares == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      test_done();
   end
   initial begin
      repeat (10) @(negedge clk);
      check(q_gate_open, 8'hFF);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      nsec = 0;
      tstep(INC_NORMAL, 0, 0, 0, 48'h5, 30'h3B9AC9F8, 48'h6, 30'h0);
      repeat (2) @(negedge clk);
      check(nsec, 1);
      tstep(INC_HOLD, 1, 1, 0, 48'h3, 30'h64, 48'h4, 30'h0);
      tstep(INC_HOLD, 0, 1, 0, 48'h7, 30'h64, 48'h7, 30'h6C);
      check(sync_sec, 48'h7);
      check(sync_ns, 30'h64);
      tstep(INC_PLUS, 0, 0, 0, 48'h9, 30'h64, 48'h9, 30'h6C);
      tstep(INC_NORMAL, 0, 0, 1, 48'h2, 30'h64, 48'h2, 30'h9E);
      tmr_adj_neg = 1'b1;
      tstep(INC_NORMAL, 0, 0, 1, 48'h2, 30'h64, 48'h2, 30'h3A);
      tmr_wr_sub = 16'h8000;
      incr_sub = 16'h8000;
      tstep(INC_NORMAL, 0, 0, 0, 48'h1, 30'h64, 48'h1, 30'h6D);
      check(tmr_sub, 16'h0000);
      incr_sub = 16'h0000;
      for (int i = 0; i < 8; i++) begin
         c = i % 3 == 0 ? INC_NORMAL : i % 3 == 1 ? INC_PLUS : INC_MINUS;
         n = 30'(rnd() % 32'h3B000000 + 16);
         da = {16'h0, rnd()};
         tstep(c, 0, 1, 0, da, n, da, n + 8 + (c == 1) - (c == 2));
      end
      cmp_sec = 48'h1234;
      cmp_ns_hi = 22'h0ABCDE;
      tstep(INC_NORMAL, 0, 0, 0, 48'h1234, 30'h0ABCDE00, 48'h1234,
         30'h0ABCDE08);
      repeat (2) @(negedge clk);
      check(timer_cmp_match, 1);
      cmp_sec = 48'h1235;
      repeat (3) @(negedge clk);
      check(timer_cmp_match, 0);
      for (int i = 0; i < 4; i++) begin
         q_pending = rnd() | 8'h01;
         idle_slope = rnd();
         repeat (3) @(negedge clk);
         check({q_grant_valid, q_grant}, {1'b1, hi(q_pending)});
      end
      cbs_en = 1'b1;
      idle_slope = 16'h0010;
      q_pending = 8'h80;
      q_sending = 8'h80;
      repeat (3) @(negedge clk);
      check(q_grant_valid, 0);
      q_sending = 8'h00;
      repeat (8) @(negedge clk);
      check({q_grant_valid, q_grant}, 4'hF);
      cbs_en = 1'b0;
      q_pending = 8'h00;
      for (int q = 0; q < 8; q++) gate_on[q*16 +: 16] = 16'(q + 1);
      gate_en = 1'b1;
      repeat (4) @(negedge clk);
      cnt = '{default: 0};
      repeat (10) begin
         @(negedge clk);
         for (int q = 0; q < 8; q++) cnt[q] += q_gate_open[q];
      end
      for (int q = 0; q < 8; q++) check(cnt[q], q + 1);
      frame(0, AS_MCAST, ETH_PTP, 4'h0, 0);
      type_id[15:0] = ETH_PTP;
      type_en = 4'h1;
      for (int m = 1; m < 4; m++) frame(0, PTP_MCAST, ETH_PTP, m, 1);
      da = {rnd(), rnd() & 32'h0000FFFF} >> 16;
      filt_addr[47:0] = da ^ 48'hFF;
      filt_byte_mask[5:0] = 6'h01;
      filt_en = 4'h1;
      type_en = 4'h0;
      frame(0, da, 16'h0800, 4'h0, 1);
      filt_byte_mask[5:0] = 6'h00;
      frame(0, da, 16'h0800, 4'h0, 0);
      one_step_en = 1'b1;
      frame(1, AS_MCAST, ETH_PTP, 4'h0, 0);
      test_done();
   end
endmodule
